// *** hdl/fmo_defines.vh ***
`ifndef FMO_DEFINES_VH
`define FMO_DEFINES_VH

// instruction fields
`define FMO_OPC_HI        31
`define FMO_OPC_LO        26
`define FMO_FMT_HI        25
`define FMO_FMT_LO        21
`define FMO_TST_HI        20
`define FMO_TST_LO        16
`define FMO_SRC_HI        15
`define FMO_SRC_LO        11
`define FMO_DST_HI        10
`define FMO_DST_LO        6
`define FMO_FN_HI         5
`define FMO_FN_LO         0
`define FMO_FN3_HI        5
`define FMO_FN3_LO        3
`define FMO_FMT3_HI       2
`define FMO_FMT3_LO       0

// opcodes and function codes
`define FMO_OPC_MAJOR     6'h11
`define FMO_OPC_EXT       6'h13
`define FMO_FN_MOVE_ZERO  6'h12
`define FMO_FN_MUL        6'h02
`define FMO_FN_NEG        6'h07
`define FMO_FN3_MUL_SUB   3'h5
`define FMO_FN3_NMUL_ADD  3'h6
`define FMO_SUB_MOVE_TO   5'h04

// operand format codes
`define FMO_FMT_SINGLE    5'h10
`define FMO_FMT_DOUBLE    5'h11
`define FMO_FMT3_SINGLE   3'h0
`define FMO_FMT3_DOUBLE   3'h1

// rounding modes
`define FMO_RM_NEAREST    2'h0
`define FMO_RM_ZERO       2'h1
`define FMO_RM_PLUS       2'h2
`define FMO_RM_MINUS      2'h3

// float layouts
`define FMO_SGL_EW        8
`define FMO_SGL_MW        23
`define FMO_DBL_EW        11
`define FMO_DBL_MW        52
`define FMO_SGL_SIGN      31
`define FMO_DBL_SIGN      63
`define FMO_WORD_HI       31

`endif

// *** hdl/fmo_fused_core.v ***
`timescale 1ns/1ns
`include "fmo_defines.vh"

module fmo_fused_core #(
    parameter EW = 11,
    parameter MW = 52
) (
    // operands, result = a * b + c
    input  wire [EW+MW:0] mul_a,
    input  wire [EW+MW:0] mul_b,
    input  wire [EW+MW:0] add_c,
    input  wire [1:0]     round_mode,
    // result and flags
    output reg  [EW+MW:0] result,
    output reg            inexact,
    output reg            overflow,
    output reg            underflow
);

localparam PW = 2 * (MW + 1);
localparam W  = PW + 4;
localparam XW = EW + 3;
localparam signed [XW-1:0] BIAS = {{(XW-EW+1){1'b0}}, {(EW-1){1'b1}}};
localparam signed [XW-1:0] EMAX = {3'b000, {EW{1'b1}}};
localparam signed [XW-1:0] TWO  = {{(XW-2){1'b0}}, 2'b10};
localparam signed [XW-1:0] ONE  = {{(XW-1){1'b0}}, 1'b1};

////////////////////////////////////////////////////////////////////////////////
// right shift that folds lost bits into a sticky lsb
function [W-1:0] shr_sticky;
    input [W-1:0]  v;
    input [XW-1:0] amt;
    integer i;
    reg [W-1:0] r;
    reg s;
    begin
        r = v;
        s = 1'b0;
        for (i = 0; i < W; i = i + 1) begin
            if (i < amt) begin
                s = s | r[0];
                r = r >> 1;
            end
        end
        shr_sticky = {r[W-1:1], r[0] | s};
    end
endfunction

function [7:0] lead_zeros;
    input [W-1:0] v;
    integer i;
    integer n;
    reg f;
    begin
        n = W;
        f = 1'b0;
        for (i = W - 1; i >= 0; i = i - 1) begin
            if (!f && v[i]) begin
                n = W - 1 - i;
                f = 1'b1;
            end
        end
        lead_zeros = n[7:0];
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
reg                 ps, cs, rs, pz, cz, g, st, inc, big;
reg signed [XW-1:0] ep, ec, diff, ebig, eres;
reg [PW-1:0]        prod;
reg [W-1:0]         pv, cv, sum, norm;
reg [7:0]           lz;
reg [MW:0]          mant;
reg [MW+1:0]        mr;

// operands are taken as normal or zero here; specials still reach this unit, and fmo_exec discards that result
always @* begin
    ps = mul_a[EW+MW] ^ mul_b[EW+MW];
    cs = add_c[EW+MW];
    pz = (mul_a[EW+MW-1:MW] == {EW{1'b0}}) || (mul_b[EW+MW-1:MW] == {EW{1'b0}});
    cz = (add_c[EW+MW-1:MW] == {EW{1'b0}});
    prod = {1'b1, mul_a[MW-1:0]} * {1'b1, mul_b[MW-1:0]};
    pv = {1'b0, prod, 3'b000};
    cv = {2'b00, 1'b1, add_c[MW-1:0], {(MW+3){1'b0}}};
    ep = $signed({3'b000, mul_a[EW+MW-1:MW]}) + $signed({3'b000, mul_b[EW+MW-1:MW]}) - BIAS;
    ec = $signed({3'b000, add_c[EW+MW-1:MW]});
    diff = ep - ec;
    ebig = ep;
    rs = ps;
    sum = {W{1'b0}};
    lz = 8'h00;
    norm = {W{1'b0}};
    eres = {XW{1'b0}};
    mant = {(MW+1){1'b0}};
    mr = {(MW+2){1'b0}};
    g = 1'b0;
    st = 1'b0;
    inc = 1'b0;
    big = 1'b0;
    inexact = 1'b0;
    overflow = 1'b0;
    underflow = 1'b0;
    result = {(EW+MW+1){1'b0}};
    if (pz && cz) begin
        // exact zero sum: sign follows the operands, or the mode on a tie
        result[EW+MW] = (ps == cs) ? ps : (round_mode == `FMO_RM_MINUS);
    end else if (pz) begin
        result = add_c;
    end else begin
        if (cz) begin
            cv = {W{1'b0}};
        end else if (!diff[XW-1]) begin
            cv = shr_sticky(cv, diff);
        end else begin
            ebig = ec;
            pv = shr_sticky(pv, -diff);
        end
        if (ps == cs) begin
            sum = pv + cv;
        end else if (pv >= cv) begin
            sum = pv - cv;
        end else begin
            sum = cv - pv;
            rs = cs;
        end
        if (sum == {W{1'b0}}) begin
            result[EW+MW] = (round_mode == `FMO_RM_MINUS);
        end else begin
            lz = lead_zeros(sum);
            norm = sum << lz;
            eres = ebig + TWO - $signed({{(XW-8){1'b0}}, lz});
            mant = norm[W-1:W-1-MW];
            g = norm[W-2-MW];
            st = |norm[W-3-MW:0];
            // single rounding of the exact sum
            case (round_mode)
                `FMO_RM_NEAREST: inc = g & (st | mant[0]);
                `FMO_RM_ZERO:    inc = 1'b0;
                `FMO_RM_PLUS:    inc = !rs & (g | st);
                default:         inc = rs & (g | st);
            endcase
            mr = {1'b0, mant} + {{(MW+1){1'b0}}, inc};
            if (mr[MW+1]) begin
                eres = eres + ONE;
                mant = mr[MW+1:1];
            end else begin
                mant = mr[MW:0];
            end
            inexact = g | st;
            big = (round_mode == `FMO_RM_ZERO) || (round_mode == `FMO_RM_PLUS && rs)
                || (round_mode == `FMO_RM_MINUS && !rs);
            if (eres >= EMAX) begin
                overflow = 1'b1;
                inexact = 1'b1;
                if (big) begin
                    result = {rs, EMAX[EW-1:0] - {{(EW-1){1'b0}}, 1'b1}, {MW{1'b1}}};
                end else begin
                    result = {rs, EMAX[EW-1:0], {MW{1'b0}}};
                end
            end else if (eres[XW-1] || eres == {XW{1'b0}}) begin
                // tiny results are not denormalised here
                underflow = 1'b1;
                result = {rs, {(EW+MW){1'b0}}};
            end else begin
                result = {rs, eres[EW-1:0], mant[MW-1:0]};
            end
        end
    end
end

endmodule

// *** hdl/fmo_exec.v ***
`timescale 1ns/1ns
`include "fmo_defines.vh"

// How it works
// - move-if-zero copies first source to destination when integer test is zero
// - move-if-zero with nonzero integer test leaves the destination unchanged
// - destination not holding a format value stays undefined after a skipped move
// - move-if-zero is non-arithmetic and raises no arithmetic exception
// - multiply-subtract computes sources product minus addend, rounded once
// - fused family may follow either arithmetic model; accuracy may differ
// - negated multiply-add rounds product plus addend once, then flips the sign
// - multiply writes the rounded product of both sources
// - negate flips only the sign bit, same format
// - negate of a NaN operand signals invalid operation
// - word move puts low 32 integer bits into low float word
// - register specifiers must be valid for the format, else result undefined
// - a source not in the format gives an undefined result
// - multiply family raises unusable, reserved and five arithmetic exceptions; here invalid is never raised, a NaN traps as unimplemented
// - move-if-zero raises only unusable, reserved and unimplemented operation

module fmo_exec (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // issue
    input  wire        issue_valid,
    input  wire [31:0] issue_instr,
    input  wire        coproc_usable,
    input  wire [1:0]  round_mode,
    // operand values
    input  wire [63:0] first_float_src,
    input  wire [63:0] second_float_src,
    input  wire [63:0] float_addend_reg,
    input  wire [63:0] integer_register,
    // write back
    output reg         done,
    output reg         wr_en,
    output reg  [4:0]  wr_index,
    output reg  [63:0] wr_data,
    // exceptions
    output reg         exc_coproc_unusable,
    output reg         exc_reserved,
    output reg         fp_unimplemented,
    output reg         fp_invalid,
    output reg         fp_overflow,
    output reg         fp_underflow,
    output reg         fp_inexact
);

localparam [2:0] OP_NONE      = 3'h0;
localparam [2:0] OP_MOVE_ZERO = 3'h1;
localparam [2:0] OP_MUL_SUB   = 3'h2;
localparam [2:0] OP_NMUL_ADD  = 3'h3;
localparam [2:0] OP_MUL       = 3'h4;
localparam [2:0] OP_NEG       = 3'h5;
localparam [2:0] OP_MOVE_TO   = 3'h6;

////////////////////////////////////////////////////////////////////////////////
// operand classification

// true for NaN, infinity or denormal in the selected format
function not_normal;
    input [63:0] v;
    input        dbl;
    begin
        if (dbl) begin
            not_normal = (v[62:52] == 11'h7FF) || (v[62:52] == 11'h000 && v[51:0] != 52'h0);
        end else begin
            not_normal = (v[30:23] == 8'hFF) || (v[30:23] == 8'h00 && v[22:0] != 23'h0);
        end
    end
endfunction

function is_nan;
    input [63:0] v;
    input        dbl;
    begin
        if (dbl) begin
            is_nan = (v[62:52] == 11'h7FF) && (v[51:0] != 52'h0);
        end else begin
            is_nan = (v[30:23] == 8'hFF) && (v[22:0] != 23'h0);
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// decode

wire [5:0] opc  = issue_instr[`FMO_OPC_HI:`FMO_OPC_LO];
wire [4:0] fmt5 = issue_instr[`FMO_FMT_HI:`FMO_FMT_LO];
wire [5:0] fn6  = issue_instr[`FMO_FN_HI:`FMO_FN_LO];
wire [2:0] fn3  = issue_instr[`FMO_FN3_HI:`FMO_FN3_LO];
wire [2:0] fmt3 = issue_instr[`FMO_FMT3_HI:`FMO_FMT3_LO];
wire [4:0] sidx = issue_instr[`FMO_SRC_HI:`FMO_SRC_LO];
wire [4:0] didx = issue_instr[`FMO_DST_HI:`FMO_DST_LO];

reg [2:0] op;
reg       dbl;
reg       fmt_ok;

always @* begin
    op = OP_NONE;
    dbl = 1'b0;
    fmt_ok = 1'b0;
    if (opc == `FMO_OPC_MAJOR) begin
        dbl = (fmt5 == `FMO_FMT_DOUBLE);
        fmt_ok = (fmt5 == `FMO_FMT_SINGLE) || dbl;
        if (fmt5 == `FMO_SUB_MOVE_TO) begin
            op = OP_MOVE_TO;
            fmt_ok = 1'b1;
        end else if (fn6 == `FMO_FN_MOVE_ZERO) begin
            op = OP_MOVE_ZERO;
        end else if (fn6 == `FMO_FN_MUL) begin
            op = OP_MUL;
        end else if (fn6 == `FMO_FN_NEG) begin
            op = OP_NEG;
        end
    end else if (opc == `FMO_OPC_EXT) begin
        dbl = (fmt3 == `FMO_FMT3_DOUBLE);
        fmt_ok = (fmt3 == `FMO_FMT3_SINGLE) || dbl;
        if (fn3 == `FMO_FN3_MUL_SUB) begin
            op = OP_MUL_SUB;
        end else if (fn3 == `FMO_FN3_NMUL_ADD) begin
            op = OP_NMUL_ADD;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// fused multiply-add units, one per format

// multiply-subtract flips the addend sign; plain multiply adds a zero
reg  [63:0] addend;
wire        arith_op = (op == OP_MUL) || (op == OP_MUL_SUB) || (op == OP_NMUL_ADD);
wire [63:0] sign_mix = first_float_src ^ second_float_src;

always @* begin
    addend = float_addend_reg;
    if (op == OP_MUL) begin
        // a signed zero addend keeps the sign of a zero product
        addend = 64'h0;
        addend[`FMO_DBL_SIGN] = dbl & sign_mix[`FMO_DBL_SIGN];
        addend[`FMO_SGL_SIGN] = !dbl & sign_mix[`FMO_SGL_SIGN];
    end else if (op == OP_MUL_SUB) begin
        if (dbl) begin
            addend[`FMO_DBL_SIGN] = ~float_addend_reg[`FMO_DBL_SIGN];
        end else begin
            addend[`FMO_SGL_SIGN] = ~float_addend_reg[`FMO_SGL_SIGN];
        end
    end
end

wire [31:0] sgl_res;
wire        sgl_inexact;
wire        sgl_overflow;
wire        sgl_underflow;
wire [63:0] dbl_res;
wire        dbl_inexact;
wire        dbl_overflow;
wire        dbl_underflow;

// exact-sum then single rounding, the fused model of the family
fmo_fused_core #(
    .EW (`FMO_SGL_EW),
    .MW (`FMO_SGL_MW)
) u_sgl (
    .mul_a      (first_float_src[`FMO_WORD_HI:0]),
    .mul_b      (second_float_src[`FMO_WORD_HI:0]),
    .add_c      (addend[`FMO_WORD_HI:0]),
    .round_mode (round_mode),
    .result     (sgl_res),
    .inexact    (sgl_inexact),
    .overflow   (sgl_overflow),
    .underflow  (sgl_underflow)
);

fmo_fused_core #(
    .EW (`FMO_DBL_EW),
    .MW (`FMO_DBL_MW)
) u_dbl (
    .mul_a      (first_float_src),
    .mul_b      (second_float_src),
    .add_c      (addend),
    .round_mode (round_mode),
    .result     (dbl_res),
    .inexact    (dbl_inexact),
    .overflow   (dbl_overflow),
    .underflow  (dbl_underflow)
);

wire [63:0] fused_res = dbl ? dbl_res : {32'h0, sgl_res};
wire        fused_ix  = dbl ? dbl_inexact : sgl_inexact;
wire        fused_ov  = dbl ? dbl_overflow : sgl_overflow;
wire        fused_un  = dbl ? dbl_underflow : sgl_underflow;

// specials and denormals are left to software
wire        special = not_normal(first_float_src, dbl) || not_normal(second_float_src, dbl)
                   || ((op != OP_MUL) && not_normal(float_addend_reg, dbl));

////////////////////////////////////////////////////////////////////////////////
// result selection

reg        next_done;
reg        next_wr_en;
reg [4:0]  next_wr_index;
reg [63:0] next_wr_data;
reg        next_unusable;
reg        next_reserved;
reg        next_unimpl;
reg        next_invalid;
reg        next_overflow;
reg        next_underflow;
reg        next_inexact;

always @* begin
    next_done = issue_valid;
    next_wr_en = 1'b0;
    next_wr_index = didx;
    next_wr_data = 64'h0;
    next_unusable = 1'b0;
    next_reserved = 1'b0;
    next_unimpl = 1'b0;
    next_invalid = 1'b0;
    next_overflow = 1'b0;
    next_underflow = 1'b0;
    next_inexact = 1'b0;
    if (!issue_valid) begin
        next_done = 1'b0;
    end else if (!coproc_usable) begin
        next_unusable = 1'b1;
    end else if (op == OP_NONE || !fmt_ok) begin
        next_reserved = 1'b1;
    end else begin
        // register specifiers are used as given; a bad pairing is the
        // issuer's problem and yields whatever the operand buses carry
        case (op)
            OP_MOVE_ZERO: begin
                // no arithmetic flags at all, whatever the operand holds
                next_wr_en = (integer_register == 64'h0);
                next_wr_data = dbl ? first_float_src : {32'h0, first_float_src[`FMO_WORD_HI:0]};
            end
            OP_MOVE_TO: begin
                // upper half of a wide register is undefined; zero is cheapest
                next_wr_en = 1'b1;
                next_wr_index = sidx;
                next_wr_data = {32'h0, integer_register[`FMO_WORD_HI:0]};
            end
            OP_NEG: begin
                next_wr_en = 1'b1;
                next_invalid = is_nan(first_float_src, dbl);
                if (dbl) begin
                    next_wr_data = first_float_src;
                    next_wr_data[`FMO_DBL_SIGN] = ~first_float_src[`FMO_DBL_SIGN];
                end else begin
                    next_wr_data = {32'h0, first_float_src[`FMO_WORD_HI:0]};
                    next_wr_data[`FMO_SGL_SIGN] = ~first_float_src[`FMO_SGL_SIGN];
                end
            end
            default: begin
                if (special || fused_un) begin
                    // tiny results trap too, so no denormal logic is needed
                    next_unimpl = 1'b1;
                    next_underflow = fused_un && !special;
                end else begin
                    next_wr_en = arith_op;
                    next_wr_data = fused_res;
                    next_overflow = fused_ov;
                    next_inexact = fused_ix;
                    if (op == OP_NMUL_ADD) begin
                        if (dbl) begin
                            next_wr_data[`FMO_DBL_SIGN] = ~fused_res[`FMO_DBL_SIGN];
                        end else begin
                            next_wr_data[`FMO_SGL_SIGN] = ~fused_res[`FMO_SGL_SIGN];
                        end
                    end
                end
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// output registers

always @(posedge clk_sys) begin
    if (rst) begin
        done <= 1'b0;
        wr_en <= 1'b0;
        wr_index <= 5'h00;
        wr_data <= 64'h0;
        exc_coproc_unusable <= 1'b0;
        exc_reserved <= 1'b0;
        fp_unimplemented <= 1'b0;
        fp_invalid <= 1'b0;
        fp_overflow <= 1'b0;
        fp_underflow <= 1'b0;
        fp_inexact <= 1'b0;
    end else begin
        done <= next_done;
        wr_en <= next_wr_en;
        wr_index <= next_wr_index;
        wr_data <= next_wr_data;
        exc_coproc_unusable <= next_unusable;
        exc_reserved <= next_reserved;
        fp_unimplemented <= next_unimpl;
        fp_invalid <= next_invalid;
        fp_overflow <= next_overflow;
        fp_underflow <= next_underflow;
        fp_inexact <= next_inexact;
    end
end

endmodule

// *** verification/fmo_exec_assertions.sv ***
`timescale 1ns/1ns
`include "fmo_defines.vh"

module fmo_exec_checker (
    // clock and reset
    input wire        clk_sys,
    input wire        rst,
    // issue
    input wire        issue_valid,
    input wire [31:0] issue_instr,
    input wire        coproc_usable,
    input wire [63:0] first_float_src,
    input wire [63:0] integer_register,
    // write back and flags
    input wire        done,
    input wire        wr_en,
    input wire [4:0]  wr_index,
    input wire [63:0] wr_data,
    input wire        exc_coproc_unusable,
    input wire        exc_reserved,
    input wire        fp_unimplemented,
    input wire        fp_invalid,
    input wire        fp_overflow,
    input wire        fp_underflow,
    input wire        fp_inexact
);
    wire [5:0] opc    = issue_instr[`FMO_OPC_HI:`FMO_OPC_LO];
    wire [4:0] fmt    = issue_instr[`FMO_FMT_HI:`FMO_FMT_LO];
    wire [5:0] fn     = issue_instr[`FMO_FN_HI:`FMO_FN_LO];
    wire       major  = issue_valid && coproc_usable && opc == `FMO_OPC_MAJOR;
    wire       mzero  = major && fmt == `FMO_FMT_DOUBLE && fn == `FMO_FN_MOVE_ZERO;
    wire       neg_d  = major && fmt == `FMO_FMT_DOUBLE && fn == `FMO_FN_NEG;
    wire       mtc    = major && fmt == `FMO_SUB_MOVE_TO;
    // 0x12..0x17 are never a format nor a move sub-opcode
    wire       badfmt = major && fn == `FMO_FN_MUL && fmt[4:3] == 2'b10 && fmt[2:1] != 2'b00;
    wire       nan    = &first_float_src[62:52] && |first_float_src[51:0];
    wire       arith  = fp_invalid | fp_overflow | fp_underflow | fp_inexact | fp_unimplemented;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////
    float_move_if_zero_copy_a: assert property (
        mzero && integer_register == 64'h0 |=> wr_en && wr_data == $past(first_float_src))
        else $error("move-if-zero did not copy the source");
    float_move_if_zero_skip_a: assert property (
        mzero && integer_register != 64'h0 |=> done && !wr_en)
        else $error("move-if-zero wrote with a nonzero test");
    float_move_if_zero_quiet_a: assert property (
        mzero |=> !arith)
        else $error("move-if-zero raised an arithmetic flag");
    neg_sign_a: assert property (
        neg_d |=> wr_en && wr_data == ($past(first_float_src) ^ 64'h8000000000000000))
        else $error("negate did not flip only the sign");
    neg_nan_a: assert property (
        neg_d |=> fp_invalid == $past(nan))
        else $error("negate invalid flag does not match operand");
    word_move_a: assert property (
        mtc |=> wr_en && wr_index == $past(issue_instr[15:11])
            && wr_data[31:0] == $past(integer_register[31:0]))
        else $error("word move wrote the wrong place or value");
    unusable_a: assert property (
        issue_valid && !coproc_usable |=> exc_coproc_unusable && !wr_en && !exc_reserved)
        else $error("disabled coprocessor not refused");
    bad_format_a: assert property (
        badfmt |=> exc_reserved && !wr_en)
        else $error("unsupported format not reserved");
    answer_once_a: assert property (
        issue_valid |=> done ##1 (done == $past(issue_valid)))
        else $error("done not one cycle after issue");
    idle_quiet_a: assert property (
        !issue_valid |=> !done && !wr_en)
        else $error("output without an issue");
endmodule

bind fmo_exec fmo_exec_checker fmo_exec_checker_i (.*);

// *** verification/fpu_move_mul_negate_ops_bench.sv ***
`timescale 1ns/1ns
`include "fmo_defines.vh"

module fpu_move_mul_negate_ops_bench;
    typedef struct {
        logic [31:0] ins;
        logic        cu;
        logic [1:0]  rm;
        logic [63:0] a;
        logic [63:0] b;
        logic [63:0] c;
        logic [63:0] ir;
        logic        we;
        logic [63:0] dat;
        logic [6:0]  fl;
    } fmo_row_t;

    localparam [63:0] D1 = 64'h3FF0000000000000;
    localparam [63:0] D2 = 64'h4000000000000000;
    localparam [63:0] D3 = 64'h4008000000000000;
    localparam [63:0] DN = 64'h7FF8000000000001;
    localparam [63:0] DZ = 64'h8000000000000000;
    localparam [4:0]  SD = `FMO_FMT_DOUBLE;
    localparam [4:0]  SS = `FMO_FMT_SINGLE;

    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        issue_valid = 1'b0;
    logic [31:0] issue_instr = 32'h0;
    logic        coproc_usable = 1'b1;
    logic [1:0]  round_mode = 2'h0;
    logic [63:0] first_float_src = 64'h0;
    logic [63:0] second_float_src = 64'h0;
    logic [63:0] float_addend_reg = 64'h0;
    logic [63:0] integer_register = 64'h0;
    wire         done;
    wire         wr_en;
    wire  [4:0]  wr_index;
    wire  [63:0] wr_data;
    wire  [6:0]  flags;
    int          fail_count = 0;
    int          checks_done = 0;
    fmo_row_t    rows[$];

    fmo_exec fmo_exec_i (
        .clk_sys(clk_sys), .rst(rst), .issue_valid(issue_valid), .issue_instr(issue_instr),
        .coproc_usable(coproc_usable), .round_mode(round_mode),
        .first_float_src(first_float_src), .second_float_src(second_float_src),
        .float_addend_reg(float_addend_reg), .integer_register(integer_register),
        .done(done), .wr_en(wr_en), .wr_index(wr_index), .wr_data(wr_data),
        .exc_coproc_unusable(flags[6]), .exc_reserved(flags[5]),
        .fp_unimplemented(flags[4]), .fp_invalid(flags[3]), .fp_overflow(flags[2]),
        .fp_underflow(flags[1]), .fp_inexact(flags[0])
    );

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////
    function automatic [31:0] c1(input [4:0] fmt, input [5:0] fn);
        c1 = {`FMO_OPC_MAJOR, fmt, 5'h03, 5'h02, 5'h07, fn};
    endfunction
    function automatic [31:0] c1x(input [2:0] fn3, input [2:0] fmt3);
        c1x = {`FMO_OPC_EXT, 5'h01, 5'h03, 5'h02, 5'h07, fn3, fmt3};
    endfunction

    task automatic add(input [31:0] ins, input cu, input [1:0] rm, input [63:0] a, b, c, ir,
                       input we, input [63:0] dat, input [6:0] fl);
        rows.push_back('{ins, cu, rm, a, b, c, ir, we, dat, fl});
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic drive(input fmo_row_t r);
        issue_valid <= 1'b1;
        issue_instr <= r.ins;
        coproc_usable <= r.cu;
        round_mode <= r.rm;
        first_float_src <= r.a;
        second_float_src <= r.b;
        float_addend_reg <= r.c;
        integer_register <= r.ir;
    endtask

    // word move targets its source field, the others their destination field
    task automatic expect_row(input fmo_row_t r);
        chk(done, 1'b1);
        chk(wr_en, r.we);
        if (r.we === 1'b1) begin
            chk(wr_index, (r.ins[25:21] == `FMO_SUB_MOVE_TO) ? 5'h02 : 5'h07);
            chk(wr_data, r.dat);
        end
        chk(flags, r.fl);
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        // about 70 cycles of work; a hang is cut off well beyond that
        #200000;
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish;
    end

    initial begin
        add(c1(SD, `FMO_FN_MUL), 1, 0, D2, D3, 0, 0, 1, 64'h4018000000000000, 0);
        add(c1(SS, `FMO_FN_MUL), 1, 0, 32'h40000000, 32'h40400000, 0, 0, 1, 32'h40C00000, 0);
        add(c1x(`FMO_FN3_MUL_SUB, 1), 1, 0, D2, D3, D1, 0, 1, 64'h4014000000000000, 0);
        add(c1x(`FMO_FN3_MUL_SUB, 0), 1, 0, 32'h40000000, 32'h40400000, 32'h3F800000, 0, 1,
            32'h40A00000, 0);
        add(c1x(`FMO_FN3_NMUL_ADD, 1), 1, 0, D2, D3, D1, 0, 1, 64'hC01C000000000000, 0);
        for (int m = 0; m < 4; m++) begin
            add(c1(SD, `FMO_FN_MUL), 1, m, 64'h7FE0000000000000, D2, 0, 0, 1,
                m[0] ? 64'h7FEFFFFFFFFFFFFF : 64'h7FF0000000000000, 7'h05);
            add(c1(SD, `FMO_FN_MUL), 1, m, 64'h3FF0000000000001, 64'h3FF0000000000001, 0, 0, 1,
                (m == 2) ? 64'h3FF0000000000003 : 64'h3FF0000000000002, 7'h01);
        end
        add(c1(SD, `FMO_FN_MUL), 1, 0, DN, D2, 0, 0, 0, 0, 7'h10);
        add(c1(SD, `FMO_FN_NEG), 1, 0, D1, 0, 0, 0, 1, 64'hBFF0000000000000, 0);
        add(c1(SS, `FMO_FN_NEG), 1, 0, 32'h3F800000, 0, 0, 0, 1, 32'hBF800000, 0);
        add(c1(SD, `FMO_FN_NEG), 1, 0, DN, 0, 0, 0, 1, 64'hFFF8000000000001, 7'h08);
        add(c1(SD, `FMO_FN_MOVE_ZERO), 1, 0, D3, 0, 0, 0, 1, D3, 0);
        add(c1(SD, `FMO_FN_MOVE_ZERO), 1, 0, DN, 0, 0, 0, 1, DN, 0);
        add(c1(SS, `FMO_FN_MOVE_ZERO), 1, 0, {32'hFFFFFFFF, 32'h40400000}, 0, 0, 0, 1,
            32'h40400000, 0);
        // only the upper half of the test register is set
        add(c1(SD, `FMO_FN_MOVE_ZERO), 1, 0, D3, 0, 0, 64'h100000000, 0, 0, 0);
        add(c1(5'h14, `FMO_FN_MOVE_ZERO), 1, 0, D3, 0, 0, 0, 0, 0, 7'h20);
        add(c1(SD, `FMO_FN_MOVE_ZERO), 0, 0, D3, 0, 0, 0, 0, 0, 7'h40);
        add({`FMO_OPC_MAJOR, `FMO_SUB_MOVE_TO, 5'h00, 5'h02, 11'h000}, 1, 0, 0, 0, 0,
            64'h89ABCDEF01234567, 1, 64'h0000000001234567, 0);
        add(c1(SD, `FMO_FN_MUL), 0, 0, D2, D3, 0, 0, 0, 0, 7'h40);
        add(c1(5'h14, `FMO_FN_MUL), 0, 0, D2, D3, 0, 0, 0, 0, 7'h40);
        add(c1(5'h14, `FMO_FN_MUL), 1, 0, D2, D3, 0, 0, 0, 0, 7'h20);
        add(c1x(`FMO_FN3_MUL_SUB, 3'h4), 1, 0, D2, D3, D1, 0, 0, 0, 7'h20);
        add(c1(SD, `FMO_FN_MUL), 1, 0, DZ, D2, 0, 0, 1, DZ, 0);
        add(c1(SD, `FMO_FN_MUL), 1, 0, 64'h0010000000000000, 64'h3FE0000000000000, 0, 0, 0, 0,
            7'h12);

        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i]) begin
            @(posedge clk_sys);
            drive(rows[i]);
            @(posedge clk_sys);
            issue_valid <= 1'b0;
            @(negedge clk_sys);
            expect_row(rows[i]);
            $display("row %0d finished", i);
        end

        // back to back issue, then outputs must fall
        @(posedge clk_sys);
        drive(rows[0]);
        @(posedge clk_sys);
        drive(rows[10]);
        @(negedge clk_sys);
        expect_row(rows[0]);
        @(posedge clk_sys);
        issue_valid <= 1'b0;
        @(negedge clk_sys);
        expect_row(rows[10]);
        @(negedge clk_sys);
        chk({done, wr_en, flags}, 0);
        $display("back to back finished");

        // an issue that meets reset gives no answer; issue right after release works
        @(posedge clk_sys);
        drive(rows[0]);
        rst <= 1'b1;
        @(posedge clk_sys);
        issue_valid <= 1'b0;
        @(negedge clk_sys);
        chk({done, wr_en, flags}, 0);
        @(posedge clk_sys);
        rst <= 1'b0;
        drive(rows[2]);
        @(posedge clk_sys);
        issue_valid <= 1'b0;
        @(negedge clk_sys);
        expect_row(rows[2]);
        $display("reset finished");
        tally_and_finish;
    end
endmodule
